/* File: logic/irq_entry_map.vh */
// Constants for the interrupt entry state capture block
`ifndef IRQ_ENTRY_MAP_VH
`define IRQ_ENTRY_MAP_VH
// APB register byte offsets
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_MASK 12'h008
`define REG_PSW 12'h00C
`define REG_RET 12'h010
`define REG_CHAN 12'h014
`define REG_SAVED_PSW 12'h018
// State word field positions
`define PSW_D0 0
`define PSW_D5 5
`define PSW_REGSET 6
`define PSW_BASESUP 7
`define PSW_FPCOMPAT 8
`define PSW_QW 9
`define PSW_RESET 36'h000000000
// Status and mask bit positions
`define ST_ENTRY 0
`define ST_CHAN 1
`define ST_IOBLOCK 2
// Control bit positions
`define CTRL_ALLOW_IO 0
`define CTRL_RECOVER 1
// Instruction class codes
`define CLS_OTHER 4'h0
`define CLS_REPEAT 4'h1
`define CLS_TERM_GO 4'h2
`define CLS_TERM_SKIP 4'h3
`define CLS_TEST_GO 4'h4
`define CLS_TEST_SKIP 4'h5
`define CLS_UJUMP 4'h6
`define CLS_CJUMP_GO 4'h7
`define CLS_CJUMP_TAKEN 4'h8
// Interrupt kind codes
`define KIND_IO 3'h0
`define KIND_OPERAND_PAR 3'h1
`define KIND_INSTR_PAR 3'h2
`define KIND_CREG_PAR 3'h3
`define KIND_GUARD 3'h4
`define KIND_TIMED 3'h5
`define KIND_PROGRAM 3'h6
// Register address windows
`define USER_LO_A 7'h01
`define USER_HI_A 7'h1D
`define USER_LO_B 7'h40
`define USER_HI_B 7'h4F
`define EXEC_LO 7'h50
`define EXEC_HI 7'h7D
`endif

/* File: logic/interrupt_entry_state_capture.v */
// Interrupt entry: return address choice, state word forcing, channel latch, I/O hold-off
//
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "irq_entry_map.vh"
module interrupt_entry_state_capture #(
  parameter AW = 18,
  parameter CW = 6
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg irq,
  // Interrupt acceptance from the instruction control section
  input wire int_accept,
  input wire [2:0] int_kind,
  input wire int_chan_valid,
  input wire [CW-1:0] int_chan,
  input wire [3:0] instr_class,
  input wire alt_bank,
  input wire late_detect,
  input wire from_execute,
  input wire [AW-1:0] cur_addr,
  input wire [AW-1:0] exec_addr,
  input wire [AW-1:0] jump_target,
  input wire [AW-1:0] rel_base,
  input wire io_int_req,
  input wire allow_io_op,
  input wire recover_req,
  input wire store_channel_num_op,
  // Address formation request
  input wire [AW-1:0] displacement,
  input wire [AW-1:0] index_value,
  input wire [3:0] index_field,
  input wire indirect_flag,
  input wire [4:0] partial_field,
  input wire [6:0] function_code,
  input wire double_second,
  input wire [6:0] reg_ref,
  // Results
  output reg [AW-1:0] return_addr,
  output reg return_valid,
  output reg [35:0] processor_state_word,
  output reg io_int_enable,
  output reg io_int_take,
  output reg [CW-1:0] chan_store_data,
  output reg chan_store_valid,
  output reg [AW-1:0] abs_addr,
  output reg abs_addr_valid,
  output reg reg_user_hit,
  output reg reg_exec_hit
);

  // Limitations: vector fetch, fault detection and the capture instruction itself sit in
  // the instruction control section; this block only supplies what they read.
  // The channel latch holds one number, so a second qualifying entry before the
  // handler stores it loses the first; the I/O hold-off is what protects it.
  // Only the low 32 bits of the state word are reachable over the bus, so the
  // upper base fields are left as they stand when the handler restores the word.
  // Priority among simultaneous sources is resolved before int_accept arrives.

  // Return choice codes: plain P, one beyond, two beyond, or the jump target
  localparam [1:0] PICK_P = 2'h0;
  localparam [1:0] PICK_P1 = 2'h1;
  localparam [1:0] PICK_P2 = 2'h2;
  localparam [1:0] PICK_JUMP = 2'h3;
  localparam [AW-1:0] STEP_ONE = {{(AW-1){1'b0}}, 1'b1};
  localparam [AW-1:0] STEP_TWO = {{(AW-2){1'b0}}, 2'h2};

  reg [CW-1:0] chan_latch;
  reg [35:0] saved_psw;
  wire [2:0] status;
  wire [2:0] st_set;
  reg [2:0] mask;
  reg [AW-1:0] next_return;
  reg [AW-1:0] ref_addr;
  reg [1:0] bank_pick;
  reg [1:0] ret_pick;
  reg next_io_enable;
  wire wr;
  wire rd;
  wire wr_ctrl;
  wire wr_status;
  wire wr_mask;
  wire wr_psw;
  wire reopen_io;
  wire addr_err;
  wire [2:0] clr;
  wire chan_kind;

  // True when a register reference falls in the set picked by the selector
  function reg_in_set;
    input [6:0] r;
    input exec_sel;
    begin
      if (exec_sel) begin
        reg_in_set = (r >= `EXEC_LO) && (r <= `EXEC_HI);
      end else begin
        reg_in_set = ((r >= `USER_LO_A) && (r <= `USER_HI_A)) || ((r >= `USER_LO_B) && (r <= `USER_HI_B));
      end
    end
  endfunction

  // Which of P, P+1, P+2 or the jump target an instruction class leaves behind;
  // shared by both fault groups so their class handling cannot drift apart
  function [1:0] class_pick;
    input [3:0] cls;
    input [1:0] other_pick;
    begin
      case (cls)
        `CLS_REPEAT: class_pick = PICK_P;
        `CLS_TERM_GO, `CLS_TEST_GO, `CLS_CJUMP_GO: class_pick = PICK_P1;
        `CLS_TERM_SKIP, `CLS_TEST_SKIP: class_pick = PICK_P2;
        `CLS_UJUMP, `CLS_CJUMP_TAKEN: class_pick = PICK_JUMP;
        default: class_pick = other_pick;
      endcase
    end
  endfunction

  // Bus strobes; a refused address matches no register, so a bad write is dropped
  assign wr = psel & penable & pwrite;
  assign rd = psel & ~penable & ~pwrite;
  assign wr_ctrl = wr & (paddr == `REG_CTRL);
  assign wr_status = wr & (paddr == `REG_STATUS);
  assign wr_mask = wr & (paddr == `REG_MASK);
  assign wr_psw = wr & (paddr == `REG_PSW);
  // Refused: beyond the last register or not word aligned
  assign addr_err = (paddr > `REG_SAVED_PSW) | (paddr[1:0] != 2'h0);
  assign clr = wr_status ? pwdata[2:0] : 3'h0;
  assign chan_kind = (int_kind == `KIND_IO) & int_chan_valid;
  assign reopen_io = allow_io_op | recover_req | (wr_ctrl & (pwdata[`CTRL_ALLOW_IO] | pwdata[`CTRL_RECOVER]));

  // Return address choice; reference is the execute instruction when it fetched the faulting one
  always @* begin
    ref_addr = from_execute ? exec_addr : cur_addr;
    // Overlap with an alternate bank fetch has already advanced past the next word
    bank_pick = alt_bank ? PICK_P2 : PICK_P1;
    ret_pick = PICK_P1;
    case (int_kind)
      `KIND_OPERAND_PAR, `KIND_IO: begin
        // Class decides; ordinary instructions follow the bank timing
        ret_pick = class_pick(instr_class, bank_pick);
      end
      `KIND_CREG_PAR, `KIND_GUARD: begin
        // Class decides; ordinary instructions always return one beyond
        ret_pick = class_pick(instr_class, PICK_P1);
      end
      `KIND_TIMED: begin
        // Fault nature and detection moment decide, bank timing ignored
        ret_pick = late_detect ? PICK_P2 : PICK_P1;
      end
      `KIND_INSTR_PAR: begin
        // The faulting word never ran, so it is retried
        ret_pick = PICK_P;
      end
      default: begin
        ret_pick = PICK_P1;
      end
    endcase
    case (ret_pick)
      PICK_P: next_return = ref_addr;
      PICK_P1: next_return = ref_addr + STEP_ONE;
      PICK_P2: next_return = ref_addr + STEP_TWO;
      default: next_return = jump_target;
    endcase
  end

  // I/O enable: entry blocks, allow op or recovery reopens; entry wins if both
  always @* begin
    next_io_enable = io_int_enable;
    if (reopen_io) begin
      next_io_enable = 1'b1;
    end
    if (int_accept) begin
      next_io_enable = 1'b0;
    end
  end

  // I/O hold-off; a request is only passed on while entries are allowed
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_int_enable <= 1'b1;
      io_int_take <= 1'b0;
    end else begin
      io_int_enable <= next_io_enable;
      io_int_take <= io_int_req & io_int_enable & ~int_accept;
    end
  end

  // Channel latch: only monitor, external and I/O parity entries overwrite it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_latch <= {CW{1'b0}};
    end else if (int_accept && chan_kind) begin
      // Not addressable by instructions; read out by the store-channel op or over the bus at REG_CHAN
      chan_latch <= int_chan;
    end
  end

  // Entry actions, all applied in the accepting cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      processor_state_word <= `PSW_RESET;
      saved_psw <= `PSW_RESET;
      return_addr <= {AW{1'b0}};
      return_valid <= 1'b0;
    end else begin
      return_valid <= int_accept;
      if (int_accept) begin
        // Offset from the relative base keeps the captured address relative
        return_addr <= next_return - rel_base;
        // Interrupted state word kept for the handler to read back
        saved_psw <= processor_state_word;
        processor_state_word[`PSW_BASESUP] <= 1'b1;
        processor_state_word[`PSW_REGSET] <= 1'b1;
        processor_state_word[`PSW_FPCOMPAT] <= 1'b0;
        processor_state_word[`PSW_QW] <= 1'b0;
        processor_state_word[`PSW_D5:`PSW_D0] <= 6'h00;
      end else if (wr_psw) begin
        // Handler restores the interrupted state word; upper base fields untouched here
        processor_state_word[31:0] <= pwdata;
      end
    end
  end

  // Store-channel instruction and address formation
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_store_data <= {CW{1'b0}};
      chan_store_valid <= 1'b0;
      abs_addr <= {AW{1'b0}};
      abs_addr_valid <= 1'b0;
      reg_user_hit <= 1'b0;
      reg_exec_hit <= 1'b0;
    end else begin
      chan_store_valid <= store_channel_num_op;
      if (store_channel_num_op) begin
        chan_store_data <= chan_latch;
      end
      abs_addr_valid <= 1'b0;
      if (processor_state_word[`PSW_BASESUP] && indirect_flag) begin
        if (index_field != 4'h0) begin
          abs_addr <= displacement + index_value + {{(AW-1){1'b0}}, double_second};
          abs_addr_valid <= 1'b1;
        end else if (!(partial_field == 5'h10 || partial_field == 5'h11) || function_code > 7'h37
                     || function_code == 7'h00) begin
          abs_addr <= displacement + {{(AW-1){1'b0}}, double_second};
          abs_addr_valid <= 1'b1;
        end
      end
      reg_exec_hit <= processor_state_word[`PSW_REGSET] & reg_in_set(reg_ref, 1'b1);
      reg_user_hit <= ~processor_state_word[`PSW_REGSET] & reg_in_set(reg_ref, 1'b0);
    end
  end

  // Status events: entry, channel latched, I/O request seen while blocked
  assign st_set[`ST_ENTRY] = int_accept;
  assign st_set[`ST_CHAN] = int_accept & chan_kind;
  assign st_set[`ST_IOBLOCK] = io_int_req & ~io_int_enable;

  // One sticky bit per event; set wins over write-one-to-clear in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_status
      reg status_bit;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          status_bit <= 1'b0;
        end else begin
          status_bit <= st_set[gi] | (status_bit & ~clr[gi]);
        end
      end
      assign status[gi] = status_bit;
    end
  endgenerate

  // Mask register and the level interrupt; the output lags the status by one cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask <= 3'h0;
      irq <= 1'b0;
    end else begin
      if (wr_mask) begin
        mask <= pwdata[2:0];
      end
      irq <= |(status & mask);
    end
  end

  // APB slave: one wait-free access, read data captured in setup
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & addr_err;
      if (rd) begin
        case (paddr)
          `REG_CTRL: prdata <= {31'h00000000, io_int_enable};
          `REG_STATUS: prdata <= {29'h00000000, status};
          `REG_MASK: prdata <= {29'h00000000, mask};
          `REG_PSW: prdata <= processor_state_word[31:0];
          `REG_RET: prdata <= {{(32-AW){1'b0}}, return_addr};
          `REG_CHAN: prdata <= {{(32-CW){1'b0}}, chan_latch};
          `REG_SAVED_PSW: prdata <= saved_psw[31:0];
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

/* File: testbench/ies_monitor.sv */
// Port assertions for the interrupt entry block
`timescale 1ns/1ps
module ies_monitor #(parameter CW = 6) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire pwrite,
  input wire int_accept,
  input wire [2:0] int_kind,
  input wire int_chan_valid,
  input wire [CW-1:0] int_chan,
  input wire allow_io_op,
  input wire recover_req,
  input wire store_channel_num_op,
  input wire [35:0] processor_state_word,
  input wire io_int_enable,
  input wire io_int_take,
  input wire [CW-1:0] chan_store_data,
  input wire chan_store_valid,
  input wire return_valid
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Entry forces the executive view of the state word
  base_sup_set_a: assert property (int_accept |=> processor_state_word[7]) else $error("base flag not set");
  regset_set_a: assert property (int_accept |=> processor_state_word[6]) else $error("exec set not chosen");
  psw_clear_a: assert property (int_accept |=> processor_state_word[9:8] == 2'h0 &&
    processor_state_word[5:0] == 6'h00) else $error("designators not cleared");
  io_block_a: assert property (int_accept |=> !io_int_enable && !io_int_take) else $error("io not blocked");
  // Any write is excluded, since a control write may legally re-enable
  io_hold_a: assert property (!io_int_enable && !allow_io_op && !recover_req && !(psel && pwrite)
    |=> !io_int_enable) else $error("io enable came back");
  no_take_a: assert property (!io_int_enable |=> !io_int_take) else $error("io taken while blocked");
  chan_keep_a: assert property (int_accept && int_kind == 3'h0 && int_chan_valid ##1
    store_channel_num_op && !int_accept |=> chan_store_valid && chan_store_data == $past(int_chan, 2))
    else $error("channel not kept");
  ret_valid_a: assert property (int_accept |=> return_valid) else $error("return late");
endmodule
bind interrupt_entry_state_capture ies_monitor #(.CW(CW)) mon (.*);

/* File: testbench/ics_model.sv */
// Instruction control section model that raises accepted interrupts
`timescale 1ns/1ps
module ics_model #(parameter CUR = 18'h00100, parameter EXA = 18'h00200, parameter JMP = 18'h00300,
  parameter REL = 18'h00040) (
  input wire pclk,
  output logic int_accept,
  output logic [2:0] int_kind,
  output logic int_chan_valid,
  output logic [5:0] int_chan,
  output logic [3:0] instr_class,
  output logic alt_bank,
  output logic late_detect,
  output logic from_execute,
  output logic [17:0] cur_addr,
  output logic [17:0] exec_addr,
  output logic [17:0] jump_target,
  output logic [17:0] rel_base
);
  initial begin
    {int_accept, int_kind, int_chan_valid, int_chan, instr_class, alt_bank, late_detect, from_execute} = 18'h00000;
    {cur_addr, exec_addr, jump_target, rel_base} = {CUR, EXA, JMP, REL};
  end
  // One-cycle acceptance; channel lines inverted after it so stale values never match
  task take(input [2:0] k, input [3:0] c, input a, input x, input [5:0] ch);
    @(posedge pclk);
    int_accept <= 1'b1;
    {int_kind, instr_class, alt_bank, from_execute, int_chan} <= {k, c, a, x, ch};
    int_chan_valid <= (k == 3'h0);
    @(posedge pclk);
    int_accept <= 1'b0;
    int_chan_valid <= 1'b0;
    int_chan <= ~ch;
  endtask
  // Timed fault entry with alternate bank set, so only the detection moment may matter
  task take_timed(input late);
    late_detect <= late;
    take(3'h5, 4'h0, 1'b1, 1'b0, 6'h00);
    late_detect <= 1'b0;
  endtask
endmodule

/* File: testbench/interrupt_entry_state_capture_tb.sv */
// Self-checking bench for the interrupt entry block
`timescale 1ns/1ps
`include "irq_entry_map.vh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin miscompares++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end
module interrupt_entry_state_capture_tb;
  localparam CUR = 18'h00100, EXA = 18'h00200, JMP = 18'h00300, REL = 18'h00040;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, io_int_req = 1'b0;
  logic store_channel_num_op = 1'b0, allow_io_op = 1'b0, recover_req = 1'b0, indirect_flag = 1'b1;
  logic double_second = 1'b0, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd, prdata;
  logic [17:0] displacement = 18'h00100, index_value = 18'h00023, return_addr, abs_addr;
  logic [17:0] cur_addr, exec_addr, jump_target, rel_base;
  logic [3:0] index_field = 4'h3, instr_class;
  logic [4:0] partial_field = 5'h00;
  logic [6:0] function_code = 7'h01, reg_ref = 7'h01;
  logic [5:0] int_chan, chan_store_data;
  logic [2:0] int_kind;
  logic [35:0] processor_state_word;
  logic pready, pslverr, irq, int_accept, int_chan_valid, alt_bank, late_detect, from_execute, return_valid;
  logic io_int_enable, io_int_take, chan_store_valid, abs_addr_valid, reg_user_hit, reg_exec_hit;
  int miscompares = 0, n_tests = 0;
  interrupt_entry_state_capture uut (.*);
  ics_model #(.CUR(CUR), .EXA(EXA), .JMP(JMP), .REL(REL)) m (.*);
  initial begin
    forever #10 pclk = ~pclk;
  end
  task stop_test;
    $display("compares %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // One APB transfer; the wait for pready is bounded
  task apb(input w, input [11:0] a, input [31:0] d);
    int i;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin @(posedge pclk); i++; end while (pready !== 1'b1 && i < 20);
    if (i >= 20) begin miscompares++; stop_test; end
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // Pulse the store-channel op straight after an acceptance
  task stc(input [5:0] ch);
    store_channel_num_op <= 1'b1;
    @(posedge pclk);
    store_channel_num_op <= 1'b0;
    #1 `CHK(chan_store_valid, 1'b1)
    `CHK(chan_store_data, ch)
  endtask
  function [17:0] ex(input [3:0] c, input a, input x);
    logic [17:0] p;
    p = (x ? EXA : CUR) - REL;
    case (c)
      4'h1: ex = p;
      4'h2, 4'h4, 4'h7: ex = p + 18'h1;
      4'h3, 4'h5: ex = p + 18'h2;
      4'h6, 4'h8: ex = JMP - REL;
      default: ex = a ? p + 18'h2 : p + 18'h1;
    endcase
  endfunction
  initial begin
    repeat (5) @(posedge pclk);
    `CHK(io_int_enable, 1'b1)
    `CHK(processor_state_word, 36'h000000000)
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    `CHK(reg_user_hit, 1'b1)
    apb(1'b1, `REG_PSW, 32'hFFFFFF3F);
    m.take(3'h1, 4'h0, 1'b1, 1'b0, 6'h00);
    #1 `CHK(processor_state_word[9:0], 10'h0C0)
    `CHK(io_int_enable, 1'b0)
    apb(1'b0, `REG_PSW, 32'h0);
    `CHK(rd, 32'hFFFFFCC0)
    reg_ref <= 7'h50;
    repeat (2) @(posedge pclk);
    `CHK(reg_exec_hit, 1'b1)
    `CHK(abs_addr, 18'h00123)
    {index_field, double_second} <= 5'h01;
    repeat (2) @(posedge pclk);
    `CHK(abs_addr, 18'h00101)
    `CHK(abs_addr_valid, 1'b1)
    partial_field <= 5'h10;
    repeat (2) @(posedge pclk);
    `CHK(abs_addr_valid, 1'b0)
    $display("state word test done");
    // Every instruction class, then bank, execute and instruction parity cases
    for (int c = 0; c < 9; c++) begin
      m.take(3'h1, c[3:0], 1'b1, 1'b0, 6'h00);
      #1 `CHK(return_addr, ex(c[3:0], 1'b1, 1'b0))
    end
    m.take(3'h1, 4'h0, 1'b0, 1'b0, 6'h00);
    #1 `CHK(return_addr, ex(4'h0, 1'b0, 1'b0))
    m.take(3'h1, 4'h0, 1'b1, 1'b1, 6'h00);
    #1 `CHK(return_addr, ex(4'h0, 1'b1, 1'b1))
    m.take(3'h2, 4'h3, 1'b1, 1'b0, 6'h00);
    #1 `CHK(return_addr, CUR - REL)
    m.take_timed(1'b1);
    #1 `CHK(return_addr, CUR - REL + 18'h2)
    m.take_timed(1'b0);
    #1 `CHK(return_addr, CUR - REL + 18'h1)
    $display("return test done");
    @(posedge pclk);
    io_int_req <= 1'b1;
    m.take(3'h0, 4'h0, 1'b0, 1'b0, 6'h05);
    stc(6'h05);
    m.take(3'h0, 4'h0, 1'b0, 1'b0, 6'h09);
    stc(6'h09);
    `CHK(io_int_take, 1'b0)
    apb(1'b0, `REG_STATUS, 32'h0);
    `CHK(rd[0], 1'b1)
    `CHK(irq, 1'b0)
    apb(1'b1, `REG_MASK, 32'h1);
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'b1)
    apb(1'b1, `REG_STATUS, 32'h7);
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'b0)
    // Channel already stored, so the handler re-enables I/O now
    apb(1'b1, `REG_CTRL, 32'h1);
    repeat (2) @(posedge pclk);
    `CHK(io_int_take, 1'b1)
    apb(1'b0, 12'h01C, 32'h0);
    `CHK(er, 1'b1)
    `CHK(rd, 32'h0)
    $display("channel and register test done");
    // Guard entry blocks I/O again; the allow op and then recovery reopen it
    m.take(3'h4, 4'h0, 1'b1, 1'b0, 6'h00);
    #1 `CHK(return_addr, CUR - REL + 18'h1)
    `CHK(io_int_enable, 1'b0)
    @(posedge pclk);
    allow_io_op <= 1'b1;
    @(posedge pclk);
    allow_io_op <= 1'b0;
    #1 `CHK(io_int_enable, 1'b1)
    m.take(3'h6, 4'h0, 1'b0, 1'b0, 6'h00);
    #1 `CHK(io_int_enable, 1'b0)
    @(posedge pclk);
    recover_req <= 1'b1;
    @(posedge pclk);
    recover_req <= 1'b0;
    #1 `CHK(io_int_enable, 1'b1)
    $display("reopen test done");
    stop_test;
  end
endmodule
